// ===== wdt_pkg.sv
package wdt_pkg;
  localparam logic [15:0] WDT_IDX_CLKSEL = 16'hffb0;
  localparam logic [15:0] WDT_IDX_CTRL1 = 16'hffb1;
  localparam logic [15:0] WDT_IDX_CTRL2 = 16'hffb2;
  localparam logic [15:0] WDT_IDX_COUNT = 16'hffb3;
  localparam int WDT_AW = 18;
  localparam logic [3:0] WDT_CLKSEL_RST = 4'h0;
  localparam logic [7:0] WDT_COUNT_RST = 8'h00;
  localparam logic [7:0] WDT_COUNT_MAX = 8'hff;
  localparam logic [10:0] WDT_IRST_OSC_CYC = 11'h200;
  localparam logic [12:0] WDT_SYS_MASK_FULL = 13'h1fff;
  localparam logic [10:0] WDT_OSC_DIV_LAST = 11'h7ff;
  localparam int B1_CWG = 7;
  localparam int B1_CWE = 6;
  localparam int B1_KWG = 5;
  localparam int B1_KWE = 4;
  localparam int B1_RG = 3;
  localparam int B1_RUN = 2;
  localparam int B1_CG = 1;
  localparam int B1_CAUSE = 0;
  localparam int B2_WRAP = 7;
  localparam int B2_MG = 6;
  localparam int B2_MODE = 5;
  localparam int B2_IG = 4;
  localparam int B2_IEN = 3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [0:0] {WDT_ST_RUN = 1'b0, WDT_ST_IRST = 1'b1} wdt_state_t;
  typedef struct packed {logic valid; logic [15:0] idx; logic [7:0] data;} wdt_wr_t;
  typedef struct packed {logic valid; logic [15:0] idx;} wdt_rd_t;
  function automatic logic wdt_hit(input logic [WDT_AW-1:0] a);
    return (a[1:0] == 2'h0) && (a[17:2] >= WDT_IDX_CLKSEL) && (a[17:2] <= WDT_IDX_COUNT);
  endfunction
endpackage

// ===== wdt_prescaler.sv
`timescale 1ns/100ps
module wdt_prescaler import wdt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_osc_clk,
  input wire logic i_medium_speed,
  input wire logic [3:0] i_sel,
  output logic o_tick,
  output logic o_osc_edge
);
  logic [12:0] sys_cnt_reg;
  logic [10:0] osc_cnt_reg;
  logic osc_prev_reg;
  logic osc_edge;
  logic [12:0] mask;
  assign osc_edge = i_osc_clk & ~osc_prev_reg;
  assign mask = WDT_SYS_MASK_FULL >> (3'h7 - i_sel[2:0]);
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sys_cnt_reg <= 13'h0000;
      osc_cnt_reg <= 11'h000;
      osc_prev_reg <= 1'b0;
      o_osc_edge <= 1'b0;
    end
    else
    begin
      sys_cnt_reg <= sys_cnt_reg + 13'h0001;
      osc_prev_reg <= i_osc_clk;
      o_osc_edge <= osc_edge;
      if (osc_edge)
        osc_cnt_reg <= osc_cnt_reg + 11'h001;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_tick <= 1'b0;
    else if (i_sel[3])
      o_tick <= (sys_cnt_reg & mask) == mask;
    else
      o_tick <= ~i_medium_speed & osc_edge & (osc_cnt_reg == WDT_OSC_DIV_LAST);
  end
endmodule

// ===== wdt_axi_slave.sv
`timescale 1ns/100ps
module wdt_axi_slave import wdt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WDT_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [WDT_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [7:0] i_rmux,
  output wdt_wr_t o_wr,
  output wdt_rd_t o_rd
);
  logic [WDT_AW-1:0] aw_reg;
  logic [7:0] wd_reg;
  logic wen_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic aw_hs;
  logic w_hs;
  logic fire;
  logic [WDT_AW-1:0] aw_cur;
  assign aw_hs = i_awvalid & o_awready;
  assign w_hs = i_wvalid & o_wready;
  assign fire = (aw_got_reg | aw_hs) & (w_got_reg | w_hs);
  assign aw_cur = aw_got_reg ? aw_reg : i_awaddr;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_reg <= '0;
      wd_reg <= 8'h00;
      wen_reg <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= AXI_OKAY;
      o_wr <= '0;
    end
    else
    begin
      o_wr <= '0;
      if (aw_hs)
        aw_reg <= i_awaddr;
      if (w_hs)
      begin
        wd_reg <= i_wdata[7:0];
        wen_reg <= i_wstrb[0];
      end
      if (fire)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        o_awready <= 1'b0;
        o_wready <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wdt_hit(aw_cur) ? AXI_OKAY : AXI_SLVERR;
        o_wr.valid <= wdt_hit(aw_cur) & (w_hs ? i_wstrb[0] : wen_reg);
        o_wr.idx <= aw_cur[17:2];
        o_wr.data <= w_hs ? i_wdata[7:0] : wd_reg;
      end
      else
      begin
        if (aw_hs)
        begin
          aw_got_reg <= 1'b1;
          o_awready <= 1'b0;
        end
        if (w_hs)
        begin
          w_got_reg <= 1'b1;
          o_wready <= 1'b0;
        end
      end
      if (o_bvalid & i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= AXI_OKAY;
      o_rd <= '0;
    end
    else
    begin
      o_rd <= '0;
      if (i_arvalid & o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= wdt_hit(i_araddr) ? {24'h000000, i_rmux} : 32'h00000000;
        o_rresp <= wdt_hit(i_araddr) ? AXI_OKAY : AXI_SLVERR;
        o_rd.valid <= wdt_hit(i_araddr);
        o_rd.idx <= i_araddr[17:2];
      end
      else if (o_rvalid & i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
endmodule

// ===== wdt_timer_top.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module wdt_timer_top import wdt_pkg::*;
#(
  parameter logic [10:0] IRST_CYCLES = WDT_IRST_OSC_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_osc_clk,
  input wire logic i_external_reset_pin,
  input wire logic i_medium_speed,
  input wire logic [WDT_AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [WDT_AW-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic o_int_reset,
  output logic o_wrap_irq
);
  if (IRST_CYCLES == 11'h000 || IRST_CYCLES > WDT_IRST_OSC_CYC)
  begin : g_chk
    $error("IRST_CYCLES must lie between 1 and 512");
  end

  wdt_wr_t wr;
  wdt_rd_t rd;
  logic [7:0] rmux;
  logic tick;
  logic osc_edge;
  logic [3:0] clock_select_field_reg;
  logic count_write_enable_reg;
  logic control_write_enable_reg;
  logic timer_run_reg;
  logic reset_cause_flag_reg;
  logic wrap_flag_reg;
  logic wrap_armed_reg;
  logic mode_select_reg;
  logic wrap_irq_enable_reg;
  logic [7:0] watchdog_count_reg;
  logic [10:0] irst_cnt_reg;
  wdt_state_t state_reg;
  wdt_state_t state_next;
  logic sreset;
  logic blk_rst;
  logic w_sel;
  logic w_one;
  logic w_two;
  logic w_cnt;
  logic cnt_load;
  logic step;
  logic ovf;
  logic interval;
  logic irst_done;

  assign sreset = i_rst | i_external_reset_pin;
  assign blk_rst = sreset | (state_reg == WDT_ST_IRST);
  assign w_sel = wr.valid && wr.idx == WDT_IDX_CLKSEL;
  assign w_one = wr.valid && wr.idx == WDT_IDX_CTRL1;
  assign w_two = wr.valid && wr.idx == WDT_IDX_CTRL2;
  assign w_cnt = wr.valid && wr.idx == WDT_IDX_COUNT;
  assign cnt_load = w_cnt & count_write_enable_reg;
  assign step = tick & timer_run_reg & ~cnt_load;
  assign ovf = step && watchdog_count_reg == WDT_COUNT_MAX;
  assign interval = mode_select_reg & ~i_medium_speed;
  assign irst_done = osc_edge && irst_cnt_reg == IRST_CYCLES - 11'h001;

  wdt_axi_slave u_bus (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_awaddr(i_s_axi_awaddr),
    .i_awvalid(i_s_axi_awvalid),
    .o_awready(o_s_axi_awready),
    .i_wdata(i_s_axi_wdata),
    .i_wstrb(i_s_axi_wstrb),
    .i_wvalid(i_s_axi_wvalid),
    .o_wready(o_s_axi_wready),
    .o_bresp(o_s_axi_bresp),
    .o_bvalid(o_s_axi_bvalid),
    .i_bready(i_s_axi_bready),
    .i_araddr(i_s_axi_araddr),
    .i_arvalid(i_s_axi_arvalid),
    .o_arready(o_s_axi_arready),
    .o_rdata(o_s_axi_rdata),
    .o_rresp(o_s_axi_rresp),
    .o_rvalid(o_s_axi_rvalid),
    .i_rready(i_s_axi_rready),
    .i_rmux(rmux),
    .o_wr(wr),
    .o_rd(rd)
  );

  wdt_prescaler u_pre (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_osc_clk(i_osc_clk),
    .i_medium_speed(i_medium_speed),
    .i_sel(clock_select_field_reg),
    .o_tick(tick),
    .o_osc_edge(osc_edge)
  );

  // Read view of the four registers.
  always_comb
  begin
    unique case (i_s_axi_araddr[17:2])
      WDT_IDX_CLKSEL: rmux = {4'hf, clock_select_field_reg};
      WDT_IDX_CTRL1: rmux = {1'b1, count_write_enable_reg, 1'b1, control_write_enable_reg,
                             1'b1, timer_run_reg, 1'b1, reset_cause_flag_reg};
      WDT_IDX_CTRL2: rmux = {wrap_flag_reg, 1'b1, mode_select_reg, 1'b1,
                             wrap_irq_enable_reg, 3'h7};
      WDT_IDX_COUNT: rmux = watchdog_count_reg;
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (blk_rst)
      clock_select_field_reg <= WDT_CLKSEL_RST;
    else if (w_sel)
      clock_select_field_reg <= wr.data[3:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (blk_rst)
    begin
      count_write_enable_reg <= 1'b0;
      control_write_enable_reg <= 1'b0;
    end
    else if (w_one)
    begin
      if (!wr.data[B1_CWG])
        count_write_enable_reg <= wr.data[B1_CWE];
      if (!wr.data[B1_KWG])
        control_write_enable_reg <= wr.data[B1_KWE];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (blk_rst)
      timer_run_reg <= 1'b0;
    else if (w_one && control_write_enable_reg && !wr.data[B1_RG])
      timer_run_reg <= wr.data[B1_RUN];
  end

  always_ff @(posedge i_clk)
  begin
    if (sreset)
      reset_cause_flag_reg <= 1'b0;
    else if (ovf && !interval)
      reset_cause_flag_reg <= 1'b1;
    else if (w_one && control_write_enable_reg && !wr.data[B1_CG] && state_reg == WDT_ST_RUN)
      reset_cause_flag_reg <= wr.data[B1_CAUSE];
  end

  always_ff @(posedge i_clk)
  begin
    if (blk_rst)
    begin
      mode_select_reg <= 1'b0;
      wrap_irq_enable_reg <= 1'b0;
    end
    else if (w_two)
    begin
      if (!wr.data[B2_MG])
        mode_select_reg <= wr.data[B2_MODE];
      if (!wr.data[B2_IG])
        wrap_irq_enable_reg <= wr.data[B2_IEN];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (blk_rst)
      wrap_flag_reg <= 1'b0;
    else if (ovf)
      wrap_flag_reg <= 1'b1;
    else if (w_two && wrap_armed_reg && !wr.data[B2_WRAP])
      wrap_flag_reg <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (blk_rst)
      wrap_armed_reg <= 1'b0;
    else if (rd.valid && rd.idx == WDT_IDX_CTRL2 && wrap_flag_reg)
      wrap_armed_reg <= 1'b1;
    else if (w_two || !wrap_flag_reg)
      wrap_armed_reg <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (blk_rst)
      watchdog_count_reg <= WDT_COUNT_RST;
    else if (cnt_load)
      watchdog_count_reg <= wr.data;
    else if (step)
      watchdog_count_reg <= watchdog_count_reg + 8'h01;
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      WDT_ST_RUN:
        if (ovf && !interval)
          state_next = WDT_ST_IRST;
      WDT_ST_IRST:
        if (irst_done)
          state_next = WDT_ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (sreset)
    begin
      state_reg <= WDT_ST_RUN;
      o_int_reset <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      o_int_reset <= state_next == WDT_ST_IRST;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (sreset || state_reg == WDT_ST_RUN)
      irst_cnt_reg <= 11'h000;
    else if (osc_edge)
      irst_cnt_reg <= irst_cnt_reg + 11'h001;
  end

  always_ff @(posedge i_clk)
  begin
    if (blk_rst)
      o_wrap_irq <= 1'b0;
    else
      o_wrap_irq <= wrap_flag_reg & wrap_irq_enable_reg & interval;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_cwe_guard: assert property (w_one && wr.data[B1_CWG] && !blk_rst
    |=> count_write_enable_reg == $past(count_write_enable_reg))
    else $error("count enable changed without guard");
  a_count_locked: assert property (w_cnt && !count_write_enable_reg && !blk_rst && !step
    |=> $stable(watchdog_count_reg))
    else $error("counter written while locked");
  a_kwe_guard: assert property (w_one && wr.data[B1_KWG] && !blk_rst
    |=> $stable(control_write_enable_reg))
    else $error("control enable changed without guard");
  a_run_guard: assert property (w_one && (wr.data[B1_RG] || !control_write_enable_reg)
    && !blk_rst |=> $stable(timer_run_reg))
    else $error("run bit changed without guard");
  a_hold_stopped: assert property (!timer_run_reg && !w_cnt && !blk_rst
    |=> $stable(watchdog_count_reg))
    else $error("counter moved while stopped");
  a_cause_guard: assert property (w_one && (wr.data[B1_CG] || !control_write_enable_reg)
    && !sreset && !ovf |=> $stable(reset_cause_flag_reg))
    else $error("cause bit changed without guard");
  a_cause_set: assert property (ovf && !interval && !sreset
    |=> reset_cause_flag_reg && o_int_reset)
    else $error("overflow did not start internal reset");
  a_cause_pin: assert property (i_external_reset_pin |=> !reset_cause_flag_reg)
    else $error("pin reset left cause set");
  a_wrap_set: assert property (ovf && !blk_rst |=> wrap_flag_reg)
    else $error("wrap flag not set");
  a_wrap_auto: assert property (ovf && !interval && !sreset ##1 !sreset
    |=> !wrap_flag_reg)
    else $error("internal reset left wrap flag");
  a_wrap_clear: assert property ($fell(wrap_flag_reg) && !$past(blk_rst)
    |-> $past(wrap_armed_reg) && $past(w_two))
    else $error("wrap flag cleared without read");
  a_irq_gate: assert property (o_wrap_irq |-> $past(wrap_irq_enable_reg) && $past(interval))
    else $error("irq without enable");
  a_irst_len: assert property ($fell(o_int_reset) && !$past(sreset)
    |-> $past(irst_cnt_reg) == IRST_CYCLES - 11'h001)
    else $error("internal reset length wrong");
  a_load_resume: assert property (cnt_load && !blk_rst
    |=> watchdog_count_reg == $past(wr.data))
    else $error("counter load lost");
  a_step_one: assert property (step && !blk_rst
    |=> watchdog_count_reg == $past(watchdog_count_reg) + 8'h01)
    else $error("counter step not one");

  c_wdt_reset: cover property ($rose(o_int_reset));
  c_int_irq: cover property ($rose(o_wrap_irq));
  c_cnt_load: cover property (cnt_load ##1 step);
endmodule

// ===== wdt_timer_top_tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    n_checks = n_checks + 1; \
    if ((got) !== (ex)) \
    begin \
      err_count = err_count + 1; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end
module wdt_timer_top_tb import wdt_pkg::*;
;
  logic clk;
  logic rst;
  logic osc;
  logic ext_pin;
  logic med;
  logic [WDT_AW-1:0] awaddr;
  logic [WDT_AW-1:0] araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, int_reset, wrap_irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d32;
  int err_count, n_checks, k, w, osc_cnt;

  wdt_timer_top #(.IRST_CYCLES(11'h004)) dut_u (.i_clk(clk), .i_rst(rst), .i_osc_clk(osc),
    .i_external_reset_pin(ext_pin), .i_medium_speed(med), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_int_reset(int_reset), .o_wrap_irq(wrap_irq));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // The oscillator changes level every third system clock.
  always @(posedge clk)
  begin
    if (osc_cnt == 2)
    begin
      osc_cnt <= 0;
      osc <= ~osc;
    end
    else
      osc_cnt <= osc_cnt + 1;
  end

  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [WDT_AW-1:0] ad(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic wr(input logic [WDT_AW-1:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [WDT_AW-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask

  task automatic w8(input logic [15:0] idx, input logic [7:0] d);
    wr(ad(idx), d, r);
  endtask

  task automatic rc(input logic [15:0] idx, input logic [7:0] ex, input string nm);
    rd(ad(idx), d32, r);
    `CHK(nm, {24'h000000, ex}, d32)
  endtask

  task automatic wait_high(ref logic s);
    w = 0;
    while (s !== 1'b1 && w < 2000)
    begin
      @(posedge clk);
      w = w + 1;
    end
  endtask

  initial
  begin
    repeat (80000) @(posedge clk);
    err_count = err_count + 1;
    report_and_stop();
  end

  initial
  begin
    err_count = 0;
    n_checks = 0;
    osc = 1'b0;
    osc_cnt = 0;
    ext_pin = 1'b0;
    med = 1'b0;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = '0;
    wstrb = 4'hf;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(WDT_IDX_CLKSEL, 8'hf0, "clksel reset");
    rc(WDT_IDX_CTRL1, 8'haa, "ctrl1 reset");
    rc(WDT_IDX_CTRL2, 8'h57, "ctrl2 reset");
    rc(WDT_IDX_COUNT, 8'h00, "count reset");
    w8(WDT_IDX_COUNT, 8'h55);
    rc(WDT_IDX_COUNT, 8'h00, "count locked");
    w8(WDT_IDX_CTRL1, 8'hc0);
    rc(WDT_IDX_CTRL1, 8'haa, "cwe guarded");
    w8(WDT_IDX_CTRL1, 8'h40);
    rc(WDT_IDX_CTRL1, 8'hea, "cwe set");
    w8(WDT_IDX_COUNT, 8'hfc);
    rc(WDT_IDX_COUNT, 8'hfc, "count written");
    w8(WDT_IDX_CTRL1, 8'h85);
    rc(WDT_IDX_CTRL1, 8'hea, "run locked");
    w8(WDT_IDX_CTRL1, 8'hb0);
    rc(WDT_IDX_CTRL1, 8'hea, "kwe guarded");
    w8(WDT_IDX_CTRL1, 8'h90);
    rc(WDT_IDX_CTRL1, 8'hfa, "kwe set");
    // Each system tap runs two periods; the count must land on 2 or 3.
    for (k = 0; k < 8; k++)
    begin
      w8(WDT_IDX_COUNT, 8'h00);
      w8(WDT_IDX_CLKSEL, 8'h08 + k[7:0]);
      rc(WDT_IDX_CLKSEL, 8'hf8 + k[7:0], "clksel code");
      w8(WDT_IDX_CTRL1, 8'hb6);
      repeat (2 * (64 << k)) @(posedge clk);
      w8(WDT_IDX_CTRL1, 8'hb2);
      rd(ad(WDT_IDX_COUNT), d32, r);
      `CHK("tick count", 1'b1, (d32 == 32'h2 || d32 == 32'h3))
    end
    // The oscillator source is silent in medium speed and ticks every 12288 clocks otherwise.
    w8(WDT_IDX_CLKSEL, 8'h00);
    w8(WDT_IDX_COUNT, 8'h00);
    med <= 1'b1;
    w8(WDT_IDX_CTRL1, 8'hb6);
    repeat (12400) @(posedge clk);
    rc(WDT_IDX_COUNT, 8'h00, "osc medium speed");
    med <= 1'b0;
    repeat (12400) @(posedge clk);
    w8(WDT_IDX_CTRL1, 8'hb2);
    rd(ad(WDT_IDX_COUNT), d32, r);
    `CHK("osc tick", 1'b1, (d32 == 32'h1 || d32 == 32'h2))
    w8(WDT_IDX_CLKSEL, 8'h08);
    w8(WDT_IDX_COUNT, 8'h40);
    repeat (300) @(posedge clk);
    rc(WDT_IDX_COUNT, 8'h40, "count held");
    w8(WDT_IDX_CTRL2, 8'h60);
    rc(WDT_IDX_CTRL2, 8'h57, "mode guarded");
    w8(WDT_IDX_CTRL2, 8'h20);
    rc(WDT_IDX_CTRL2, 8'h77, "mode set");
    w8(WDT_IDX_CTRL2, 8'h58);
    rc(WDT_IDX_CTRL2, 8'h77, "ien guarded");
    w8(WDT_IDX_CTRL2, 8'h48);
    rc(WDT_IDX_CTRL2, 8'h7f, "ien set");
    w8(WDT_IDX_COUNT, 8'hfc);
    w8(WDT_IDX_CTRL1, 8'hb6);
    wait_high(wrap_irq);
    `CHK("wrap irq", 1'b1, wrap_irq)
    `CHK("no reset interval", 1'b0, int_reset)
    w8(WDT_IDX_CLKSEL, 8'h00);
    w8(WDT_IDX_CTRL2, 8'h50);
    rc(WDT_IDX_CTRL2, 8'hff, "wrap kept");
    w8(WDT_IDX_CTRL2, 8'h50);
    rc(WDT_IDX_CTRL2, 8'h7f, "wrap cleared");
    `CHK("irq cleared", 1'b0, wrap_irq)
    w8(WDT_IDX_CTRL1, 8'hb2);
    w8(WDT_IDX_CLKSEL, 8'h08);
    w8(WDT_IDX_CTRL2, 8'h10);
    w8(WDT_IDX_COUNT, 8'hfe);
    w8(WDT_IDX_CTRL1, 8'hb6);
    wait_high(int_reset);
    `CHK("int reset", 1'b1, int_reset)
    w = 0;
    while (int_reset === 1'b1 && w < 200)
    begin
      @(posedge clk);
      w = w + 1;
    end
    `CHK("reset span", 1'b1, (w >= 16 && w <= 32))
    rc(WDT_IDX_CTRL1, 8'hab, "cause kept");
    rc(WDT_IDX_CTRL2, 8'h57, "wrap auto clear");
    rc(WDT_IDX_COUNT, 8'h00, "count after reset");
    w8(WDT_IDX_CTRL1, 8'h90);
    w8(WDT_IDX_CTRL1, 8'hba);
    rc(WDT_IDX_CTRL1, 8'hbb, "cause guarded");
    w8(WDT_IDX_CTRL1, 8'hb8);
    rc(WDT_IDX_CTRL1, 8'hba, "cause cleared");
    w8(WDT_IDX_CTRL1, 8'hb9);
    rc(WDT_IDX_CTRL1, 8'hbb, "cause set");
    ext_pin <= 1'b1;
    repeat (2) @(posedge clk);
    ext_pin <= 1'b0;
    repeat (2) @(posedge clk);
    rc(WDT_IDX_CTRL1, 8'haa, "pin reset");
    rd(18'h00010, d32, r);
    `CHK("unmapped rresp", AXI_SLVERR, r)
    `CHK("unmapped rdata", 32'h00000000, d32)
    wr(18'h3fec1, 8'h00, r);
    `CHK("unaligned bresp", AXI_SLVERR, r)
    report_and_stop();
  end
endmodule
